// >>> logic/amc_mode_cal_ctrl.sv
// Purpose: Control word decode and calibration sequencer of a sigma-delta converter.
// Assumes: conv_valid/conv_data come from the filter on sys_clk; sclk is the host serial clock.
// Notes:   Filter arithmetic is outside; a calibration point is the next filtered result.
//
// What this block does
// - Holds 24-bit control word: mode, gain, channel, flags, then 12-bit notch code.
// - Mode 000 is normal; select-high reads return the conversion data.
// - Power-on reset clears the mode field to normal.
// - Mode 001 self-calibrates: zero on shorted inputs, full scale on reference.
// - Self-calibration end clears mode to 000 and pulls data-ready low.
// - Mode 010 does system zero-scale, flags data-ready, returns to normal.
// - Mode 011 does system full-scale, flags data-ready, returns to normal.
// - Mode 100 offset-calibrates: zero on input, full on reference, then normal.
// - Mode 101 interleaves calibration, publishing one word per six conversions.
// - Background mode updates coefficients automatically without host commands.
// - Mode 110 maps select-high transfers onto the channel's zero-scale coefficient.
// - Mode 111 maps select-high transfers onto the channel's full-scale coefficient.
// - Coefficient transfers are always 24 bits regardless of word length.
// - Coefficient writes shorter than 24 bits are dropped.
// - Select-low transfers reach the control word; only full 24-bit writes load.
// - Data-ready falls on a new word, rises after a full word is read.
// - Channel bit 0 is differential input, 1 single-ended; resets to 0.
`timescale 1ns/10ps
module amc_mode_cal_ctrl (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	// Serial link
	input  wire logic        sclk,
	input  wire logic        transmit_frame_n,
	input  wire logic        receive_frame_n,
	input  wire logic        register_select_line,
	input  wire logic        sdata_in,
	output logic             sdata_out,
	output logic             sdata_oe_n,
	output logic             result_ready_n,
	// Filter results
	input  wire logic        conv_valid,
	input  wire logic [23:0] conv_data,
	// Front end controls
	output logic [2:0]       gain_sel,
	output logic             input_select,
	output logic             sleep_request,
	output logic             output_word_length,
	output logic             excitation_current_on,
	output logic             burnout_current_on,
	output logic             unipolar_sel,
	output logic [11:0]      notch_code,
	output logic [1:0]       meas_source
);
	logic [23:0]                rx_word, tx_word_q, tx_word_d;
	logic                       rx_sel, wr_tgl, rd_tgl, rd_sel;
	logic                       tx_short_q, tx_short_d;
	logic [amc_pkg::SYNC_W-1:0] sy;
	logic                       wr_seen_q, rd_seen_q, wr_ev, rd_ev;
	amc_pkg::amc_ctrl_t         ctrl_q, ctrl_d, wr_ctrl;
	amc_pkg::amc_state_t        st_q, st_d;
	amc_pkg::amc_src_t          src_q, src_d;
	logic [2:0]                 slot_q, slot_d;
	logic [23:0]                data_q, data_d;
	logic                       rdy_n_q, rdy_n_d;
	logic [23:0]                zero_coef_q [2];
	logic [23:0]                zero_coef_d [2];
	logic [23:0]                full_coef_q [2];
	logic [23:0]                full_coef_d [2];
	logic                       chan, coef_mode;

	////////////////////////////////////////////////////////////////////////
	// Link side and crossings
	amc_serial_link u_link (
		.sclk                 (sclk),
		.transmit_frame_n     (transmit_frame_n),
		.receive_frame_n      (receive_frame_n),
		.register_select_line (register_select_line),
		.sdata_in             (sdata_in),
		.sdata_out            (sdata_out),
		.sdata_oe_n           (sdata_oe_n),
		.rstn                 (rstn),
		.tx_word              (tx_word_q),
		.tx_short             (tx_short_q),
		.rx_word              (rx_word),
		.rx_sel               (rx_sel),
		.wr_tgl               (wr_tgl),
		.rd_tgl               (rd_tgl),
		.rd_sel               (rd_sel)
	);

	// Multi-bit words are held still in the link domain until the next toggle
	amc_sync2 u_sync (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.d       ({register_select_line, receive_frame_n, rd_tgl, wr_tgl}),
		.q       (sy)
	);

	assign wr_ev     = sy[amc_pkg::SY_WR] ^ wr_seen_q;
	assign rd_ev     = sy[amc_pkg::SY_RD] ^ rd_seen_q;
	assign chan      = ctrl_q.input_select;
	assign coef_mode = (ctrl_q.op_mode == amc_pkg::MODE_ZERO_RW) || (ctrl_q.op_mode == amc_pkg::MODE_FULL_RW);
	assign wr_ctrl   = amc_pkg::amc_ctrl_t'(rx_word);

	////////////////////////////////////////////////////////////////////////
	// Sequencer, coefficients, data-ready
	always_comb begin
		ctrl_d      = ctrl_q;
		st_d        = st_q;
		src_d       = src_q;
		slot_d      = slot_q;
		data_d      = data_q;
		rdy_n_d     = rdy_n_q;
		zero_coef_d = zero_coef_q;
		full_coef_d = full_coef_q;

		// Full data word read releases data-ready
		if (rd_ev && rd_sel && !coef_mode) begin
			rdy_n_d = 1'b1;
		end

		// Filter results; a new word beats a same-cycle read release
		if (conv_valid) begin
			unique case (st_q)
				amc_pkg::ST_ZERO: begin
					zero_coef_d[chan] = conv_data;
					if (ctrl_q.op_mode == amc_pkg::MODE_SYS_ZERO) begin
						st_d           = amc_pkg::ST_RUN;
						ctrl_d.op_mode = amc_pkg::MODE_NORMAL;
						rdy_n_d        = 1'b0;
					end else begin
						st_d  = amc_pkg::ST_FULL;
						src_d = amc_pkg::SRC_REF;
					end
				end
				amc_pkg::ST_FULL: begin
					full_coef_d[chan] = conv_data;
					st_d              = amc_pkg::ST_RUN;
					src_d             = amc_pkg::SRC_INPUT;
					ctrl_d.op_mode    = amc_pkg::MODE_NORMAL;
					rdy_n_d           = 1'b0;
				end
				amc_pkg::ST_RUN: begin
					if (ctrl_q.op_mode == amc_pkg::MODE_BKG_CAL) begin
						slot_d = (slot_q == amc_pkg::BKG_SLOT_LAST) ? amc_pkg::BKG_SLOT_ZERO
						                                            : slot_q + amc_pkg::SLOT_STEP;
						if (slot_q == amc_pkg::BKG_SLOT_ZERO) begin
							zero_coef_d[chan] = conv_data;
							src_d             = amc_pkg::SRC_REF;
						end else if (slot_q == amc_pkg::BKG_SLOT_FULL) begin
							full_coef_d[chan] = conv_data;
							src_d             = amc_pkg::SRC_INPUT;
						end else if (slot_q == amc_pkg::BKG_SLOT_LAST) begin
							data_d  = conv_data;
							rdy_n_d = 1'b0;
							src_d   = amc_pkg::SRC_SHORT;
						end
					end else begin
						data_d  = conv_data;
						rdy_n_d = 1'b0;
					end
				end
				default: begin
					st_d = amc_pkg::ST_RUN;
				end
			endcase
		end

		// Control-word writes take priority over the filter's mode, state, source and slot updates this cycle
		if (wr_ev) begin
			if (!rx_sel) begin
				ctrl_d = wr_ctrl;
				slot_d = amc_pkg::BKG_SLOT_ZERO;
				st_d   = amc_pkg::ST_RUN;
				src_d  = amc_pkg::SRC_INPUT;
				unique case (wr_ctrl.op_mode)
					amc_pkg::MODE_SELF_CAL: begin
						st_d  = amc_pkg::ST_ZERO;
						src_d = amc_pkg::SRC_SHORT;
					end
					amc_pkg::MODE_SYS_ZERO, amc_pkg::MODE_SYS_OFFSET: begin
						st_d = amc_pkg::ST_ZERO;
					end
					amc_pkg::MODE_SYS_FULL: begin
						st_d = amc_pkg::ST_FULL;
					end
					amc_pkg::MODE_BKG_CAL: begin
						src_d = amc_pkg::SRC_SHORT;
					end
					amc_pkg::MODE_NORMAL, amc_pkg::MODE_ZERO_RW, amc_pkg::MODE_FULL_RW: begin
						st_d = amc_pkg::ST_RUN;
					end
				endcase
				if (st_d != amc_pkg::ST_RUN) begin
					rdy_n_d = 1'b1;
				end
			end else if (ctrl_q.op_mode == amc_pkg::MODE_ZERO_RW) begin
				zero_coef_d[chan] = rx_word;
			end else if (ctrl_q.op_mode == amc_pkg::MODE_FULL_RW) begin
				full_coef_d[chan] = rx_word;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q         <= amc_pkg::CTRL_RESET;
			st_q           <= amc_pkg::ST_RUN;
			src_q          <= amc_pkg::SRC_INPUT;
			slot_q         <= amc_pkg::BKG_SLOT_ZERO;
			data_q         <= 24'h000000;
			rdy_n_q        <= 1'b1;
			zero_coef_q[0] <= 24'h000000;
			zero_coef_q[1] <= 24'h000000;
			full_coef_q[0] <= 24'h000000;
			full_coef_q[1] <= 24'h000000;
		end else begin
			ctrl_q      <= ctrl_d;
			st_q        <= st_d;
			src_q       <= src_d;
			slot_q      <= slot_d;
			data_q      <= data_d;
			rdy_n_q     <= rdy_n_d;
			zero_coef_q <= zero_coef_d;
			full_coef_q <= full_coef_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read word; frozen while a read frame is open so the link samples a still word
	always_comb begin
		tx_word_d  = tx_word_q;
		tx_short_d = tx_short_q;
		if (sy[amc_pkg::SY_RDFRM_N]) begin
			tx_short_d = 1'b0;
			if (!sy[amc_pkg::SY_SEL]) begin
				tx_word_d = ctrl_q;
			end else if (ctrl_q.op_mode == amc_pkg::MODE_ZERO_RW) begin
				tx_word_d = zero_coef_q[chan];
			end else if (ctrl_q.op_mode == amc_pkg::MODE_FULL_RW) begin
				tx_word_d = full_coef_q[chan];
			end else begin
				tx_word_d  = data_q;
				tx_short_d = !ctrl_q.output_word_length;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			tx_word_q  <= 24'h000000;
			tx_short_q <= 1'b0;
			wr_seen_q  <= 1'b0;
			rd_seen_q  <= 1'b0;
		end else begin
			tx_word_q  <= tx_word_d;
			tx_short_q <= tx_short_d;
			wr_seen_q  <= sy[amc_pkg::SY_WR];
			rd_seen_q  <= sy[amc_pkg::SY_RD];
		end
	end

	// Outputs come straight from the control and state flops
	assign gain_sel              = ctrl_q.gain_sel;
	assign input_select          = ctrl_q.input_select;
	assign sleep_request         = ctrl_q.sleep_request;
	assign output_word_length    = ctrl_q.output_word_length;
	assign excitation_current_on = ctrl_q.excitation_current_on;
	assign burnout_current_on    = ctrl_q.burnout_current_on;
	assign unipolar_sel          = ctrl_q.unipolar_sel;
	assign notch_code            = ctrl_q.notch_code;
	assign meas_source           = src_q;
	assign result_ready_n        = rdy_n_q;

	////////////////////////////////////////////////////////////////////////
	chk_ctrl_load: assert property (@(posedge sys_clk) disable iff (!rstn)
		(wr_ev && !rx_sel)
		|=> (ctrl_q == $past(wr_ctrl)))
		else $error("control word not loaded");
	chk_cal_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
		(st_q != amc_pkg::ST_RUN) |-> result_ready_n)
		else $error("data-ready low during calibration");
	chk_self_seq: assert property (@(posedge sys_clk) disable iff (!rstn)
		(st_q == amc_pkg::ST_ZERO && ctrl_q.op_mode == amc_pkg::MODE_SELF_CAL && conv_valid && !wr_ev)
		|=> (st_q == amc_pkg::ST_FULL && meas_source == amc_pkg::SRC_REF))
		else $error("self calibration did not move to full scale");
	chk_cal_done: assert property (@(posedge sys_clk) disable iff (!rstn)
		(st_q == amc_pkg::ST_FULL && conv_valid && !wr_ev)
		|=> (ctrl_q.op_mode == amc_pkg::MODE_NORMAL && !result_ready_n && st_q == amc_pkg::ST_RUN))
		else $error("calibration end not reported");
	chk_sysz_done: assert property (@(posedge sys_clk) disable iff (!rstn)
		(st_q == amc_pkg::ST_ZERO && ctrl_q.op_mode == amc_pkg::MODE_SYS_ZERO && conv_valid && !wr_ev)
		|=> (st_q == amc_pkg::ST_RUN && !result_ready_n && ctrl_q.op_mode == amc_pkg::MODE_NORMAL))
		else $error("system zero step not completed");
	chk_bkg_rate: assert property (@(posedge sys_clk) disable iff (!rstn)
		(st_q == amc_pkg::ST_RUN && ctrl_q.op_mode == amc_pkg::MODE_BKG_CAL && conv_valid
		 && slot_q != amc_pkg::BKG_SLOT_LAST && !wr_ev && !rd_ev) |=> $stable(result_ready_n))
		else $error("background slot published a word");
	chk_coef_write: assert property (@(posedge sys_clk) disable iff (!rstn)
		(wr_ev && rx_sel && ctrl_q.op_mode == amc_pkg::MODE_ZERO_RW)
		|=> (zero_coef_q[$past(chan)] == $past(rx_word)))
		else $error("zero coefficient not written");
	chk_result_ready_n_release: assert property (@(posedge sys_clk) disable iff (!rstn)
		(rd_ev && rd_sel && !coef_mode && !conv_valid && !wr_ev) |=> result_ready_n)
		else $error("data-ready not released after read");
	chk_coef_len: assert property (@(posedge sys_clk) disable iff (!rstn)
		(sy[amc_pkg::SY_RDFRM_N] && sy[amc_pkg::SY_SEL] && coef_mode) |=> !tx_short_q)
		else $error("coefficient read shortened");
endmodule

// >>> logic/amc_pkg.sv
// Purpose: Shared types and constants for the converter mode and calibration control.
// Assumes: 24-bit control word, two input channels, one serial link clock.
// Notes:   Every field position, count and code used by more than one file lives here.
package amc_pkg;

	// Serial word framing
	localparam logic [4:0] WORD_BITS  = 5'h18;
	localparam logic [4:0] LAST_BIT   = 5'h17;
	localparam logic [4:0] SHORT_BITS = 5'h10;
	localparam logic [4:0] CNT_ZERO   = 5'h00;
	localparam logic [4:0] CNT_ONE    = 5'h01;

	// Background calibration: one published word per six conversions
	localparam logic [2:0] BKG_SLOT_ZERO = 3'h0;
	localparam logic [2:0] BKG_SLOT_FULL = 3'h1;
	localparam logic [2:0] BKG_SLOT_LAST = 3'h5;
	localparam logic [2:0] SLOT_STEP     = 3'h1;

	// Synchroniser lanes
	localparam int SYNC_W     = 4;
	localparam int SY_WR      = 0;
	localparam int SY_RD      = 1;
	localparam int SY_RDFRM_N = 2;
	localparam int SY_SEL     = 3;

	typedef enum logic [2:0] {
		MODE_NORMAL     = 3'h0,
		MODE_SELF_CAL   = 3'h1,
		MODE_SYS_ZERO   = 3'h2,
		MODE_SYS_FULL   = 3'h3,
		MODE_SYS_OFFSET = 3'h4,
		MODE_BKG_CAL    = 3'h5,
		MODE_ZERO_RW    = 3'h6,
		MODE_FULL_RW    = 3'h7
	} amc_mode_t;

	typedef enum logic [2:0] {
		ST_RUN  = 3'h1,
		ST_ZERO = 3'h2,
		ST_FULL = 3'h4
	} amc_state_t;

	typedef enum logic [1:0] {
		SRC_INPUT = 2'h0,
		SRC_SHORT = 2'h1,
		SRC_REF   = 2'h2
	} amc_src_t;

	// Control word, most significant field first
	typedef struct packed {
		amc_mode_t   op_mode;
		logic [2:0]  gain_sel;
		logic        input_select;
		logic        sleep_request;
		logic        output_word_length;
		logic        excitation_current_on;
		logic        burnout_current_on;
		logic        unipolar_sel;
		logic [11:0] notch_code;
	} amc_ctrl_t;

	localparam amc_ctrl_t CTRL_RESET = amc_ctrl_t'(24'h000000);

endpackage

// >>> logic/amc_sync2.sv
// Purpose: Two-flop synchroniser for levels and toggles entering the system clock.
// Assumes: Each lane changes slowly compared with the system clock.
// Notes:   Only the second stage is visible to the outside.
`timescale 1ns/10ps
module amc_sync2 (
	// Clock and reset
	input  wire logic                      sys_clk,
	input  wire logic                      rstn,
	// Lanes
	input  wire logic [amc_pkg::SYNC_W-1:0] d,
	output logic      [amc_pkg::SYNC_W-1:0] q
);
	logic [amc_pkg::SYNC_W-1:0] meta_q;

	// Frame strobe lane idles high, so it resets high to avoid a false frame
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			meta_q <= 4'h4;
			q      <= 4'h4;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule

// >>> logic/amc_serial_link.sv
// Purpose: Serial shifter on the link clock for control, coefficient and data frames.
// Assumes: Link clock runs only inside frames; frame strobes are low during a frame.
// Notes:   The frame strobes clear the per-frame counters, so no edge after a frame is needed.
`timescale 1ns/10ps
module amc_serial_link (
	// Link pins
	input  wire logic        sclk,
	input  wire logic        transmit_frame_n,
	input  wire logic        receive_frame_n,
	input  wire logic        register_select_line,
	input  wire logic        sdata_in,
	output logic             sdata_out,
	output logic             sdata_oe_n,
	// System side
	input  wire logic        rstn,
	input  wire logic [23:0] tx_word,
	input  wire logic        tx_short,
	output logic      [23:0] rx_word,
	output logic             rx_sel,
	output logic             wr_tgl,
	output logic             rd_tgl,
	output logic             rd_sel
);
	logic [4:0]  wcnt_q, wcnt_d;
	logic [23:0] wsh_q, wsh_d;
	logic [23:0] rx_word_d;
	logic        rx_sel_d, wr_tgl_d;
	logic [4:0]  rcnt_q, rcnt_d, rlen_q, rlen_d;
	logic [23:0] rsh_q, rsh_d;
	logic        out_d, oe_d, rd_tgl_d, rd_sel_d;

	////////////////////////////////////////////////////////////////////////
	// Receive: a word lands only on its 24th bit; later pulses fall away
	always_comb begin
		wcnt_d    = wcnt_q;
		wsh_d     = wsh_q;
		rx_word_d = rx_word;
		rx_sel_d  = rx_sel;
		wr_tgl_d  = wr_tgl;
		if (wcnt_q != amc_pkg::WORD_BITS) begin
			wsh_d  = {wsh_q[22:0], sdata_in};
			wcnt_d = wcnt_q + amc_pkg::CNT_ONE;
		end
		if (wcnt_q == amc_pkg::LAST_BIT) begin
			rx_word_d = {wsh_q[22:0], sdata_in};
			rx_sel_d  = register_select_line;
			wr_tgl_d  = ~wr_tgl;
		end
	end

	always_ff @(posedge sclk or negedge rstn or posedge transmit_frame_n) begin
		if (!rstn || transmit_frame_n) begin
			wcnt_q <= amc_pkg::CNT_ZERO;
			wsh_q  <= 24'h000000;
		end else begin
			wcnt_q <= wcnt_d;
			wsh_q  <= wsh_d;
		end
	end

	// Word handed to the system clock; stable until the next full write
	always_ff @(posedge sclk or negedge rstn) begin
		if (!rstn) begin
			rx_word <= 24'h000000;
			rx_sel  <= 1'b0;
			wr_tgl  <= 1'b0;
		end else begin
			rx_word <= rx_word_d;
			rx_sel  <= rx_sel_d;
			wr_tgl  <= wr_tgl_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit: first edge loads and drives the MSB, one bit per edge after
	always_comb begin
		rcnt_d = rcnt_q;
		rsh_d  = rsh_q;
		rlen_d = rlen_q;
		out_d  = sdata_out;
		oe_d   = sdata_oe_n;
		if (rcnt_q == amc_pkg::CNT_ZERO) begin
			rsh_d  = tx_word;
			out_d  = tx_word[23];
			oe_d   = 1'b0;
			rlen_d = tx_short ? amc_pkg::SHORT_BITS : amc_pkg::WORD_BITS;
			rcnt_d = amc_pkg::CNT_ONE;
		end else if (rcnt_q < rlen_q) begin
			rsh_d  = {rsh_q[22:0], 1'b0};
			out_d  = rsh_q[22];
			rcnt_d = rcnt_q + amc_pkg::CNT_ONE;
		end else if (rcnt_q == rlen_q) begin
			oe_d   = 1'b1;
			rcnt_d = rcnt_q + amc_pkg::CNT_ONE;
		end
		rd_tgl_d = rd_tgl;
		rd_sel_d = rd_sel;
		if (rcnt_q != amc_pkg::CNT_ZERO && rcnt_q == rlen_q) begin
			rd_tgl_d = ~rd_tgl;
			rd_sel_d = register_select_line;
		end
	end

	always_ff @(posedge sclk or negedge rstn or posedge receive_frame_n) begin
		if (!rstn || receive_frame_n) begin
			rcnt_q     <= amc_pkg::CNT_ZERO;
			rlen_q     <= amc_pkg::WORD_BITS;
			rsh_q      <= 24'h000000;
			sdata_out  <= 1'b0;
			sdata_oe_n <= 1'b1;
		end else begin
			rcnt_q     <= rcnt_d;
			rlen_q     <= rlen_d;
			rsh_q      <= rsh_d;
			sdata_out  <= out_d;
			sdata_oe_n <= oe_d;
		end
	end

	always_ff @(posedge sclk or negedge rstn) begin
		if (!rstn) begin
			rd_tgl <= 1'b0;
			rd_sel <= 1'b0;
		end else begin
			rd_tgl <= rd_tgl_d;
			rd_sel <= rd_sel_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	chk_excess_ignored: assert property (@(posedge sclk) disable iff (!rstn || transmit_frame_n)
		(wcnt_q == amc_pkg::WORD_BITS) |=> ($stable(rx_word) && $stable(wr_tgl)))
		else $error("word changed after its 24th bit");
	chk_full_write_only: assert property (@(posedge sclk) disable iff (!rstn)
		(wcnt_q != amc_pkg::LAST_BIT) |=> $stable(wr_tgl))
		else $error("write accepted before 24 bits");
endmodule

// >>> tb/amc_host.sv
// Purpose: Host model on the converter's five-wire serial port.
// Assumes: Link clock runs only inside frames, 6 ns period.
// Notes:   A released data line shows the inverse of the last bit, never a stale value.
`timescale 1ns/10ps
module amc_host (
	// Device side
	input  wire logic sdata_out,
	input  wire logic sdata_oe_n,
	// Host side
	output logic      sclk,
	output logic      transmit_frame_n,
	output logic      receive_frame_n,
	output logic      register_select_line,
	output logic      sdata_in
);
	logic drv;
	logic bit_q;
	assign sdata_in = !sdata_oe_n ? sdata_out : (drv ? bit_q : !bit_q);
	initial begin
		sclk = 1'b0;
		transmit_frame_n = 1'b1;
		receive_frame_n = 1'b1;
		register_select_line = 1'b0;
		drv = 1'b0;
		bit_q = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////
	// Bits past the 24th are filler; short frames show a refused write
	task automatic wr(input logic sel, input logic [23:0] w, input int n);
		register_select_line = sel;
		#12;
		transmit_frame_n = 1'b0;
		drv = 1'b1;
		for (int i = 0; i < n; i++) begin
			bit_q = (i < 24) ? w[23 - i] : !bit_q;
			#3 sclk = 1'b1;
			#3 sclk = 1'b0;
		end
		transmit_frame_n = 1'b1;
		drv = 1'b0;
		#24;
	endtask
	// First edge loads and drives the MSB; edge n+1 ends the read, so n bits need n+1 edges
	task automatic rd(input logic sel, input int n, output logic [23:0] w);
		register_select_line = sel;
		#12;
		receive_frame_n = 1'b0;
		w = 24'h000000;
		for (int k = 1; k <= n + 1; k++) begin
			#3 sclk = 1'b1;
			#3 sclk = 1'b0;
			if (k <= n) begin
				w = {w[22:0], sdata_in};
			end
		end
		receive_frame_n = 1'b1;
		#24;
	endtask
endmodule

// >>> tb/amc_mode_cal_ctrl_tb.sv
// Purpose: Self-checking bench for mode decode and calibration sequencing.
// Assumes: Host model handles all serial framing.
// Notes:   Fixed waits cover the crossing latencies; a watchdog cuts hangs.
`timescale 1ns/10ps
module amc_mode_cal_ctrl_tb;
	localparam logic [23:0] BASE = 24'h145123;
	logic        sys_clk;
	logic        rstn;
	logic        conv_valid;
	logic [23:0] conv_data;
	logic        sclk, transmit_frame_n, receive_frame_n, register_select_line;
	logic        sdata_in, sdata_out, sdata_oe_n, result_ready_n;
	logic        input_select, sleep_request, output_word_length;
	logic        excitation_current_on, burnout_current_on, unipolar_sel;
	logic [2:0]  gain_sel;
	logic [11:0] notch_code;
	logic [1:0]  meas_source;
	logic [20:0] fld;
	logic [23:0] w;
	int          fails;
	int          n_tests;
	assign fld = {gain_sel, input_select, sleep_request, output_word_length, excitation_current_on,
		burnout_current_on, unipolar_sel, notch_code};
	amc_mode_cal_ctrl u_dut (.sys_clk, .rstn, .sclk, .transmit_frame_n, .receive_frame_n, .register_select_line,
		.sdata_in, .sdata_out, .sdata_oe_n, .result_ready_n, .conv_valid, .conv_data, .gain_sel, .input_select,
		.sleep_request, .output_word_length, .excitation_current_on, .burnout_current_on, .unipolar_sel,
		.notch_code, .meas_source);
	amc_host u_host (.sdata_out, .sdata_oe_n, .sclk, .transmit_frame_n, .receive_frame_n, .register_select_line,
		.sdata_in);
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic stop_test;
		if (fails == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic cfld(input logic [23:0] e);
		chk("fields", {3'h0, e[20:0]}, {3'h0, fld});
	endtask
	task automatic crd(input logic sel, input int n, input logic [23:0] e, input string nm);
		u_host.rd(sel, n, w);
		chk(nm, e, w);
	endtask
	task automatic crdy(input logic e);
		chk("ready", {23'h0, e}, {23'h0, result_ready_n});
	endtask
	task automatic csrc(input logic [1:0] e);
		chk("source", {22'h0, e}, {22'h0, meas_source});
	endtask
	task automatic pulse(input logic [23:0] d);
		@(negedge sys_clk);
		conv_valid = 1'b1;
		conv_data = d;
		@(negedge sys_clk);
		conv_valid = 1'b0;
		repeat (2) @(negedge sys_clk);
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		cfld(24'h000000);
		crdy(1'b1);
		chk("oe", 24'h000001, {23'h0, sdata_oe_n});
		csrc(2'h0);
		crd(1'b0, 24, 24'h000000, "ctrl");
	endtask
	task automatic t_ctrl;
		u_host.wr(1'b0, 24'h0FEABC, 24);
		cfld(24'h0FEABC);
		u_host.wr(1'b0, BASE, 23);
		cfld(24'h0FEABC);
		u_host.wr(1'b0, BASE, 27);
		cfld(BASE);
		crd(1'b0, 24, BASE, "ctrl");
	endtask
	task automatic t_data;
		pulse(24'hA5C3E1);
		crdy(1'b0);
		crd(1'b1, 16, 24'h00A5C3, "data");
		crdy(1'b1);
		u_host.wr(1'b0, BASE | 24'h008000, 24);
		pulse(24'h3C5A96);
		crd(1'b1, 24, 24'h3C5A96, "data");
		u_host.wr(1'b0, BASE, 24);
	endtask
	task automatic t_self;
		u_host.wr(1'b0, BASE | 24'h200000, 24);
		csrc(2'h1);
		pulse(24'h000111);
		csrc(2'h2);
		crdy(1'b1);
		pulse(24'h7FF222);
		crdy(1'b0);
		crd(1'b0, 24, BASE, "ctrl");
		u_host.wr(1'b0, BASE | 24'hC00000, 24);
		crd(1'b1, 24, 24'h000111, "zero");
		u_host.wr(1'b0, BASE | 24'hE00000, 24);
		crd(1'b1, 24, 24'h7FF222, "full");
	endtask
	task automatic t_sys;
		for (int m = 2; m <= 4; m++) begin
			u_host.wr(1'b0, BASE | {m[2:0], 21'h0}, 24);
			csrc(2'h0);
			crdy(1'b1);
			pulse(24'h0A0A00 | m[23:0]);
			if (m == 4) begin
				csrc(2'h2);
				pulse(24'h5B5B5B);
			end
			crdy(1'b0);
			crd(1'b0, 24, BASE, "ctrl");
		end
		u_host.wr(1'b0, BASE | 24'hE00000, 24);
		crd(1'b1, 24, 24'h5B5B5B, "full");
		u_host.wr(1'b0, BASE | 24'hC00000, 24);
		crd(1'b1, 24, 24'h0A0A04, "zero");
		u_host.wr(1'b1, 24'h123456, 24);
		u_host.wr(1'b1, 24'hFEDCBA, 16);
		crd(1'b1, 24, 24'h123456, "zero");
		u_host.wr(1'b0, BASE | 24'hE20000, 24);
		u_host.wr(1'b1, 24'h0F1E2D, 24);
		crd(1'b1, 24, 24'h0F1E2D, "full");
		u_host.wr(1'b0, BASE | 24'hE00000, 24);
		crd(1'b1, 24, 24'h5B5B5B, "full");
	endtask
	task automatic t_bkg;
		u_host.wr(1'b0, BASE, 24);
		u_host.rd(1'b1, 16, w);
		u_host.wr(1'b0, BASE | 24'hA00000, 24);
		for (int s = 0; s < 6; s++) begin
			crdy(1'b1);
			pulse(24'h600000 | s[23:0]);
		end
		crdy(1'b0);
		crd(1'b1, 16, 24'h006000, "data");
		u_host.wr(1'b0, BASE | 24'hC00000, 24);
		crd(1'b1, 24, 24'h600000, "zero");
		u_host.wr(1'b0, BASE | 24'hE00000, 24);
		crd(1'b1, 24, 24'h600001, "full");
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		rstn = 1'b0;
		conv_valid = 1'b0;
		conv_data = 24'h000000;
		fails = 0;
		n_tests = 0;
		repeat (10) @(negedge sys_clk);
		rstn = 1'b1;
		repeat (4) @(negedge sys_clk);
		t_reset;
		t_ctrl;
		t_data;
		t_self;
		t_sys;
		t_bkg;
		stop_test;
	end
	// Watchdog: a hang counts as a mismatch
	initial begin
		#100000;
		fails++;
		stop_test;
	end
endmodule
